/* csmr_pkg.sv */
package csmr_pkg;

    // ----------------------------------------------------------------
    // Opcode patterns
    // ----------------------------------------------------------------
    localparam logic [14:0] RET_PAT = 15'h0009;
    localparam logic [5:0] ROT_PAT = 6'h0d;
    localparam logic [8:0] MOV1_PAT = 9'h1d7;
    localparam logic [3:0] MOV2_PAT = 4'hf;
    localparam logic [7:0] PUSH_PAT = 8'hea;

    // ----------------------------------------------------------------
    // Field positions
    // ----------------------------------------------------------------
    localparam int RET_S_BIT = 0;
    localparam int ROT_D_BIT = 9;
    localparam int ROT_A_BIT = 8;
    localparam int ST_C_BIT = 0;
    localparam int ST_Z_BIT = 2;
    localparam int ST_N_BIT = 4;

    // ----------------------------------------------------------------
    // Addressing
    // ----------------------------------------------------------------
    localparam logic [7:0] ACC_LIMIT = 8'h5f;
    localparam logic [3:0] ACC_HI_BANK = 4'hf;
    localparam logic [3:0] ACC_LO_BANK = 4'h0;
    localparam logic [11:0] IND_ADDR_0 = 12'hfe0;
    localparam logic [11:0] IND_ADDR_1 = 12'hfe8;
    localparam logic [11:0] IND_ADDR_2 = 12'hff0;
    localparam logic [11:0] IND_MASK = 12'hff8;

    // ----------------------------------------------------------------
    // Reset values
    // ----------------------------------------------------------------
    localparam logic [7:0] BYTE_RST = 8'h00;
    localparam logic [11:0] FP_RST = 12'h000;
    localparam logic [20:0] PC_RST = 21'h000000;
    localparam logic [15:0] IR_RST = 16'h0000;

    typedef struct packed {
        logic rd;
        logic we;
        logic [11:0] addr;
        logic [7:0] wdata;
    } csmr_dmem_req_t;

endpackage : csmr_pkg

/* csmr_addr_calc.sv */
`timescale 1ns/1ps

module csmr_addr_calc (
    input wire logic [11:0] base_in,
    input wire logic [6:0] offset_in,
    output logic [11:0] addr_out,
    output logic is_ind_out
);

    // ----------------------------------------------------------------
    // Offset add and indirect slot match
    // ----------------------------------------------------------------
    // Wraps within the data space; the pointer may sit near the top
    assign addr_out = base_in + {5'h00, offset_in}; // RL7
    assign is_ind_out = ((addr_out & csmr_pkg::IND_MASK) == csmr_pkg::IND_ADDR_0) ||
                        ((addr_out & csmr_pkg::IND_MASK) == csmr_pkg::IND_ADDR_1) ||
                        ((addr_out & csmr_pkg::IND_MASK) == csmr_pkg::IND_ADDR_2); // RL9

endmodule : csmr_addr_calc

/* csmr_core.sv */
// Operation
// RL1: Return opcode fixed, low bit is s
// RL2: Return pops PC; s restores shadows
// RL3: Return is one word, two cycles
// RL4: Rotate left through carry, d selects target
// RL5: a picks access bank or bank select
// RL6: Indexed move is two words, 1111 second
// RL7: Addresses are pointer plus 7-bit offset
// RL8: Code never targets PC or stack bytes
// RL9: Indirect source reads zero; dest is no-op
// RL10: Indexed move reads cycle one, writes two
// RL11: Push writes literal then decrements pointer
// RL12: Push is single cycle, no flags
// RL13: Rotate sets C N Z; others keep
// RL14: Push opcode upper byte, literal lower
`timescale 1ns/1ps

module csmr_core (
    input wire logic CLK_IN,
    input wire logic RST_N_IN,
    input wire logic [15:0] INSTR_IN,
    input wire logic INSTR_VALID_IN,
    input wire logic EXT_EN_IN,
    input wire logic [20:0] STACK_TOP_IN,
    input wire logic [7:0] WS_IN,
    input wire logic [7:0] FLAGS_SHADOW_IN,
    input wire logic [7:0] BSR_SHADOW_IN,
    input wire logic FP_LOAD_IN,
    input wire logic [11:0] FP_DATA_IN,
    input wire logic [7:0] DMEM_RDATA_IN,
    output logic FETCH_READY_OUT,
    output logic INSTR_TAKEN_OUT,
    output csmr_pkg::csmr_dmem_req_t DMEM_REQ_OUT,
    output logic STACK_POP_OUT,
    output logic [20:0] PC_OUT,
    output logic [7:0] W_OUT,
    output logic [7:0] STATUS_OUT,
    output logic [7:0] BSR_OUT,
    output logic [11:0] FP_OUT
);

    // ----------------------------------------------------------------
    // Quarter phase and cycle state
    // ----------------------------------------------------------------
    typedef enum logic [3:0] {
        Q1 = 4'h1,
        Q2 = 4'h2,
        Q3 = 4'h4,
        Q4 = 4'h8
    } csmr_q_t;

    typedef enum logic [4:0] {
        ST_IDLE = 5'h01,
        ST_EXEC = 5'h02,
        ST_RET2 = 5'h04,
        ST_MOVW = 5'h08,
        ST_MOV2 = 5'h10
    } csmr_st_t;

    csmr_q_t q_reg;
    csmr_q_t q_next;
    csmr_st_t st_reg;
    csmr_st_t st_next;
    logic [15:0] ir_reg;
    logic [7:0] rdata_reg;
    logic src_ind_reg;
    logic [11:0] src_addr_reg;
    logic [11:0] dst_addr_reg;
    logic dst_ind_reg;
    csmr_pkg::csmr_dmem_req_t dreq_reg;
    csmr_pkg::csmr_dmem_req_t dreq_next;
    logic pop_reg;
    logic [20:0] pc_reg;
    logic [7:0] w_reg;
    logic [7:0] status_reg;
    logic [7:0] bsr_reg;
    logic [11:0] fp_reg;
    logic ready_reg;
    logic taken_reg;

    // ----------------------------------------------------------------
    // Decode
    // ----------------------------------------------------------------
    wire is_ret = (ir_reg[15:1] == csmr_pkg::RET_PAT); // RL1
    wire ret_s = ir_reg[csmr_pkg::RET_S_BIT];
    wire is_rot = (ir_reg[15:10] == csmr_pkg::ROT_PAT);
    wire rot_d = ir_reg[csmr_pkg::ROT_D_BIT];
    wire rot_a = ir_reg[csmr_pkg::ROT_A_BIT];
    wire is_mov1 = (ir_reg[15:7] == csmr_pkg::MOV1_PAT); // RL6
    wire is_mov2 = (ir_reg[15:12] == csmr_pkg::MOV2_PAT); // RL6
    wire is_push = (ir_reg[15:8] == csmr_pkg::PUSH_PAT); // RL14
    wire in_exec = (st_reg == ST_EXEC);
    wire in_mov2 = (st_reg == ST_MOV2) && is_mov2;
    wire take_word = (q_reg == Q1) && INSTR_VALID_IN &&
                     (st_next == ST_EXEC || st_next == ST_MOV2);

    // ----------------------------------------------------------------
    // File register address
    // ----------------------------------------------------------------
    wire [7:0] f_lit = ir_reg[7:0];
    wire f_low = (f_lit <= csmr_pkg::ACC_LIMIT);
    wire [11:0] f_idx_addr = fp_reg + {4'h0, f_lit};
    wire [11:0] f_acc_addr = f_low ? {csmr_pkg::ACC_LO_BANK, f_lit} :
                                     {csmr_pkg::ACC_HI_BANK, f_lit};
    wire [11:0] f_bank_addr = {bsr_reg[3:0], f_lit};
    // Indexed form only for the low access window with extended set on
    wire [11:0] f_addr = rot_a ? f_bank_addr :
                         ((EXT_EN_IN && f_low) ? f_idx_addr : f_acc_addr); // RL5

    // ----------------------------------------------------------------
    // Indexed move addresses
    // ----------------------------------------------------------------
    wire [11:0] mov_addr;
    wire mov_ind;

    csmr_addr_calc u_mov_addr (
        .base_in(fp_reg),
        .offset_in(ir_reg[6:0]),
        .addr_out(mov_addr),
        .is_ind_out(mov_ind)
    );

    // ----------------------------------------------------------------
    // Rotate result
    // ----------------------------------------------------------------
    wire [7:0] rot_res = {rdata_reg[6:0], status_reg[csmr_pkg::ST_C_BIT]}; // RL4
    wire rot_c = rdata_reg[7]; // RL4
    wire [7:0] mov_data = src_ind_reg ? csmr_pkg::BYTE_RST : rdata_reg; // RL9

    // ----------------------------------------------------------------
    // Next phase and state
    // ----------------------------------------------------------------
    always_comb begin
        case (q_reg)
            Q1: q_next = Q2;
            Q2: q_next = Q3;
            Q3: q_next = Q4;
            Q4: q_next = Q1;
            default: q_next = Q1;
        endcase
    end

    always_comb begin
        st_next = st_reg;
        if (q_reg == Q1) begin
            case (st_reg)
                ST_EXEC: begin
                    if (is_ret) begin
                        st_next = ST_RET2; // RL3
                    end else if (is_mov1) begin
                        st_next = INSTR_VALID_IN ? ST_MOV2 : ST_MOVW; // RL10
                    end else begin
                        st_next = INSTR_VALID_IN ? ST_EXEC : ST_IDLE;
                    end
                end
                ST_MOVW: st_next = INSTR_VALID_IN ? ST_MOV2 : ST_MOVW;
                ST_IDLE, ST_RET2, ST_MOV2: st_next = INSTR_VALID_IN ? ST_EXEC : ST_IDLE;
                default: st_next = ST_IDLE;
            endcase
        end
    end

    // ----------------------------------------------------------------
    // Data memory request
    // ----------------------------------------------------------------
    wire rot_rd = in_exec && is_rot && (q_reg == Q2);
    wire mov_rd = in_exec && is_mov1 && (q_reg == Q4); // RL10
    wire rot_wr = in_exec && is_rot && (q_reg == Q4) && rot_d;
    wire push_wr = in_exec && is_push && (q_reg == Q4); // RL11
    wire mov_wr = in_mov2 && (q_reg == Q4) && !dst_ind_reg; // RL9

    always_comb begin
        dreq_next.rd = rot_rd || mov_rd;
        dreq_next.we = rot_wr || push_wr || mov_wr;
        dreq_next.addr = dreq_reg.addr;
        dreq_next.wdata = dreq_reg.wdata;
        if (rot_rd || rot_wr) begin
            dreq_next.addr = f_addr;
        end else if (mov_rd) begin
            dreq_next.addr = src_addr_reg;
        end else if (push_wr) begin
            dreq_next.addr = fp_reg; // RL11
        end else if (mov_wr) begin
            dreq_next.addr = dst_addr_reg; // RL10
        end
        if (rot_wr) begin
            dreq_next.wdata = rot_res;
        end else if (push_wr) begin
            dreq_next.wdata = ir_reg[7:0];
        end else if (mov_wr) begin
            dreq_next.wdata = mov_data;
        end
    end

    // ----------------------------------------------------------------
    // Sequencing registers
    // ----------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            q_reg <= Q1;
            st_reg <= ST_IDLE;
            ir_reg <= csmr_pkg::IR_RST;
            ready_reg <= 1'b0;
            taken_reg <= 1'b0;
        end else begin
            q_reg <= q_next;
            st_reg <= st_next;
            taken_reg <= take_word;
            ready_reg <= (q_next == Q1) && (st_reg != ST_EXEC || !is_ret);
            if (take_word) begin
                ir_reg <= INSTR_IN;
            end
        end
    end

    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            rdata_reg <= csmr_pkg::BYTE_RST;
            src_addr_reg <= csmr_pkg::FP_RST;
            src_ind_reg <= 1'b0;
            dst_addr_reg <= csmr_pkg::FP_RST;
            dst_ind_reg <= 1'b0;
            dreq_reg <= '0;
        end else begin
            dreq_reg <= dreq_next;
            // Memory answers combinationally while the read strobe is up
            if (dreq_reg.rd) begin
                rdata_reg <= DMEM_RDATA_IN;
            end
            if (in_exec && is_mov1 && (q_reg == Q3)) begin
                src_addr_reg <= mov_addr; // RL7
                src_ind_reg <= mov_ind;
            end
            if (in_mov2 && (q_reg == Q3)) begin
                dst_addr_reg <= mov_addr; // RL7
                dst_ind_reg <= mov_ind;
            end
        end
    end

    // ----------------------------------------------------------------
    // Core registers
    // ----------------------------------------------------------------
    // Shadow restore lands in Q3, so a shadowed status wins over flags
    always_ff @(posedge CLK_IN or negedge RST_N_IN) begin
        if (!RST_N_IN) begin
            pc_reg <= csmr_pkg::PC_RST;
            pop_reg <= 1'b0;
            w_reg <= csmr_pkg::BYTE_RST;
            status_reg <= csmr_pkg::BYTE_RST;
            bsr_reg <= csmr_pkg::BYTE_RST;
            fp_reg <= csmr_pkg::FP_RST;
        end else begin
            pop_reg <= in_exec && is_ret && (q_reg == Q4); // RL3
            if (in_exec && is_ret && (q_reg == Q4)) begin
                pc_reg <= STACK_TOP_IN; // RL2
            end
            if (in_exec && is_ret && ret_s && (q_reg == Q3)) begin
                w_reg <= WS_IN; // RL2
                status_reg <= FLAGS_SHADOW_IN; // RL2
                bsr_reg <= BSR_SHADOW_IN; // RL2
            end else if (in_exec && is_rot && (q_reg == Q4)) begin
                status_reg[csmr_pkg::ST_C_BIT] <= rot_c; // RL13
                status_reg[csmr_pkg::ST_N_BIT] <= rot_res[7]; // RL13
                status_reg[csmr_pkg::ST_Z_BIT] <= (rot_res == csmr_pkg::BYTE_RST); // RL13
                if (!rot_d) begin
                    w_reg <= rot_res; // RL4
                end
            end
            if (push_wr) begin
                fp_reg <= fp_reg - 12'h001; // RL11 RL12
            end else if (FP_LOAD_IN) begin
                fp_reg <= FP_DATA_IN;
            end
        end
    end

    assign FETCH_READY_OUT = ready_reg;
    assign INSTR_TAKEN_OUT = taken_reg;
    assign DMEM_REQ_OUT = dreq_reg;
    assign STACK_POP_OUT = pop_reg;
    assign PC_OUT = pc_reg;
    assign W_OUT = w_reg;
    assign STATUS_OUT = status_reg;
    assign BSR_OUT = bsr_reg;
    assign FP_OUT = fp_reg;

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    property p_ret_pop;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_ret && q_reg == Q4) |=>
            (STACK_POP_OUT && PC_OUT == $past(STACK_TOP_IN));
    endproperty
    a_ret_pop: assert property (p_ret_pop) else $error("Return did not pop stack"); // RL2

    property p_ret_nop;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_ret && q_reg == Q4) |=> ##1
            (st_reg == ST_RET2 && !DMEM_REQ_OUT.we && !DMEM_REQ_OUT.rd) [*4];
    endproperty
    a_ret_nop: assert property (p_ret_nop) else $error("Return second cycle not idle"); // RL3

    property p_ret_shadow;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_ret && q_reg == Q3) |=>
            (ret_s ? (W_OUT == $past(WS_IN) && BSR_OUT == $past(BSR_SHADOW_IN))
                   : (W_OUT == $past(W_OUT) && STATUS_OUT == $past(STATUS_OUT)));
    endproperty
    a_ret_shadow: assert property (p_ret_shadow) else $error("Shadow restore wrong"); // RL2

    property p_rot_res;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_rot && q_reg == Q4) |=>
            (STATUS_OUT[0] == $past(rdata_reg[7]) &&
             (rot_d ? (DMEM_REQ_OUT.we && DMEM_REQ_OUT.wdata == $past(rot_res))
                    : (W_OUT == $past(rot_res) && !DMEM_REQ_OUT.we)));
    endproperty
    a_rot_res: assert property (p_rot_res) else $error("Rotate result wrong"); // RL4

    property p_rot_addr;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_rot && q_reg == Q2 && rot_a) |=>
            (DMEM_REQ_OUT.rd && DMEM_REQ_OUT.addr == {$past(BSR_OUT[3:0]), $past(ir_reg[7:0])});
    endproperty
    a_rot_addr: assert property (p_rot_addr) else $error("Banked address wrong"); // RL5

    property p_push;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_push && q_reg == Q4) |=>
            (DMEM_REQ_OUT.we && DMEM_REQ_OUT.addr == $past(FP_OUT) &&
             DMEM_REQ_OUT.wdata == $past(ir_reg[7:0]) &&
             FP_OUT == $past(FP_OUT) - 12'h001 && STATUS_OUT == $past(STATUS_OUT));
    endproperty
    a_push: assert property (p_push) else $error("Push write or decrement wrong"); // RL11

    property p_mov_rd;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_exec && is_mov1 && q_reg == Q4) |=>
            (DMEM_REQ_OUT.rd && DMEM_REQ_OUT.addr == $past(FP_OUT) + {5'h00, $past(ir_reg[6:0])});
    endproperty
    a_mov_rd: assert property (p_mov_rd) else $error("Move source read wrong"); // RL10

    property p_mov_zero;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_mov2 && q_reg == Q4 && !dst_ind_reg && src_ind_reg) |=>
            (DMEM_REQ_OUT.we && DMEM_REQ_OUT.wdata == 8'h00);
    endproperty
    a_mov_zero: assert property (p_mov_zero) else $error("Indirect source not zero"); // RL9

    property p_mov_nop;
        @(posedge CLK_IN) disable iff (!RST_N_IN)
        (in_mov2 && q_reg == Q4 && dst_ind_reg) |=> !DMEM_REQ_OUT.we;
    endproperty
    a_mov_nop: assert property (p_mov_nop) else $error("Indirect dest was written"); // RL9

endmodule : csmr_core

/* csmr_dmem_model.sv */
`timescale 1ns/1ps

module csmr_dmem_model (
    input wire logic clk_in,
    input wire csmr_pkg::csmr_dmem_req_t req_in,
    output logic [7:0] rdata_out
);
    // ----------------------------------------------------------------
    // Data space
    // ----------------------------------------------------------------
    logic [7:0] mem [0:4095];
    logic [7:0] last_reg;
    int wr_cnt;
    // Idle bus shows the inverse, so a late sample cannot pass by luck
    assign rdata_out = req_in.rd ? mem[req_in.addr] : ~last_reg;
    initial begin
        wr_cnt = 0;
        last_reg = 8'h00;
        for (int i = 0; i < 4096; i++) begin
            mem[i] = 8'h00;
        end
    end
    always @(posedge clk_in) begin
        if (req_in.rd) begin
            last_reg <= mem[req_in.addr];
        end
        if (req_in.we) begin
            mem[req_in.addr] <= req_in.wdata;
            wr_cnt <= wr_cnt + 1;
        end
    end
endmodule : csmr_dmem_model

/* cpu_stack_move_rotate_ops_bench.sv */
`timescale 1ns/1ps

module cpu_stack_move_rotate_ops_bench;
    // ----------------------------------------------------------------
    // Harness
    // ----------------------------------------------------------------
    logic clk_in, rst_n_in, valid_in, ext_in, fpld_in, ready, taken, pop;
    logic [15:0] instr_in;
    logic [20:0] top_in, pc;
    logic [7:0] wsh_in, fsh_in, bsh_in, rdata, w, st, bank, e_w, e_st, e_bank;
    logic [11:0] fpd_in, fp;
    csmr_pkg::csmr_dmem_req_t req;
    int fails, n_tests, cyc, takes, pops;

    csmr_core u_csmr_core (
        .CLK_IN(clk_in), .RST_N_IN(rst_n_in), .INSTR_IN(instr_in),
        .INSTR_VALID_IN(valid_in), .EXT_EN_IN(ext_in), .STACK_TOP_IN(top_in),
        .WS_IN(wsh_in), .FLAGS_SHADOW_IN(fsh_in), .BSR_SHADOW_IN(bsh_in),
        .FP_LOAD_IN(fpld_in), .FP_DATA_IN(fpd_in), .DMEM_RDATA_IN(rdata),
        .FETCH_READY_OUT(ready), .INSTR_TAKEN_OUT(taken), .DMEM_REQ_OUT(req),
        .STACK_POP_OUT(pop), .PC_OUT(pc), .W_OUT(w), .STATUS_OUT(st),
        .BSR_OUT(bank), .FP_OUT(fp)
    );
    csmr_dmem_model u_csmr_dmem_model (.clk_in(clk_in), .req_in(req), .rdata_out(rdata));

    initial begin
        clk_in = 1'b0;
        forever #12.5 clk_in = ~clk_in;
    end
    // Counters of pulses; a pulse missed here would read as a lost pop or take
    always @(posedge clk_in) begin
        cyc <= cyc + 1;
        if (taken === 1'b1) begin
            takes <= takes + 1;
        end
        if (pop === 1'b1) begin
            pops <= pops + 1;
        end
        if (cyc == 2000) begin
            fails = fails + 1;
            give_verdict();
        end
    end
    // ----------------------------------------------------------------
    // Shared tasks
    // ----------------------------------------------------------------
    task automatic check(input string nm, input logic [39:0] seen, input logic [39:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fails++;
            $display("[ERR] %s expected %h seen %h", nm, exp, seen);
        end
    endtask : check
    function automatic logic [7:0] mem_at(input logic [11:0] a);
        return u_csmr_dmem_model.mem[a];
    endfunction : mem_at
    // Entered just after a Q4 edge; returns just after the next Q4 edge
    task automatic exec(input logic [15:0] wd);
        instr_in <= wd;
        valid_in <= 1'b1;
        @(posedge clk_in);
        valid_in <= 1'b0;
        repeat (3) @(posedge clk_in);
    endtask : exec
    task automatic wait1();
        @(posedge clk_in);
        #1;
    endtask : wait1
    task automatic sync();
        repeat (3) @(posedge clk_in);
    endtask : sync
    task automatic load_fp(input logic [11:0] v);
        fpd_in <= v;
        fpld_in <= 1'b1;
        @(posedge clk_in);
        fpld_in <= 1'b0;
        #1;
        check("fp load", fp, v);
        sync();
    endtask : load_fp
    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_push();
        int w0;
        load_fp(12'h001);
        w0 = u_csmr_dmem_model.wr_cnt;
        exec({csmr_pkg::PUSH_PAT, 8'ha5});
        exec({csmr_pkg::PUSH_PAT, 8'h5a});
        wait1();
        check("push first", mem_at(12'h001), 8'ha5);
        check("push second", mem_at(12'h000), 8'h5a);
        check("push pointer", fp, 12'hfff);
        check("push flags", st, e_st);
        check("push writes", u_csmr_dmem_model.wr_cnt - w0, 2);
        sync();
    endtask : t_push
    task automatic t_ret(input logic s);
        int p0, w0, k0;
        p0 = pops;
        w0 = u_csmr_dmem_model.wr_cnt;
        k0 = takes;
        top_in <= {20'habcde, s};
        wsh_in <= 8'h5a;
        fsh_in <= 8'h14;
        bsh_in <= 8'h03;
        exec({csmr_pkg::RET_PAT, s});
        check("return not ready", ready, 1'b0);
        instr_in <= {csmr_pkg::PUSH_PAT, 8'h77};
        valid_in <= 1'b1;
        @(posedge clk_in);
        valid_in <= 1'b0;
        #1;
        if (s) begin
            e_w = 8'h5a;
            e_st = 8'h14;
            e_bank = 8'h03;
        end
        check("return pc", pc, {20'habcde, s});
        check("return pops", pops - p0, 1);
        check("return w", w, e_w);
        check("return status", st, e_st);
        check("return bank", bank, e_bank);
        sync();
        wait1();
        check("second cycle refuses", fp, 12'hfff);
        check("return takes", takes - k0, 1);
        check("return writes", u_csmr_dmem_model.wr_cnt - w0, 0);
        sync();
    endtask : t_ret
    task automatic t_rot(input logic ext, a, d, input logic [7:0] f, v, input logic [11:0] ad);
        logic [7:0] r;
        r = {v[6:0], e_st[0]};
        u_csmr_dmem_model.mem[ad] = v;
        ext_in <= ext;
        exec({csmr_pkg::ROT_PAT, d, a, f});
        wait1();
        e_st = {e_st[7:5], r[7], e_st[3], r == 8'h00, e_st[1], v[7]};
        if (d) begin
            check("rotate file", mem_at(ad), r);
        end else begin
            e_w = r;
            check("rotate keeps file", mem_at(ad), v);
        end
        check("rotate w", w, e_w);
        check("rotate status", st, e_st);
        sync();
    endtask : t_rot
    // Destinations stay clear of the counter and stack-top bytes
    task automatic t_mov(input logic [11:0] b, input logic [6:0] zs, zd, input logic [3:0] hi,
                         input logic [7:0] sv, ex, input int nw);
        int w0;
        logic [11:0] da;
        da = b + zd;
        load_fp(b);
        u_csmr_dmem_model.mem[b + zs] = sv;
        u_csmr_dmem_model.mem[da] = 8'hc3;
        w0 = u_csmr_dmem_model.wr_cnt;
        exec({csmr_pkg::MOV1_PAT, zs});
        exec({hi, 5'h15, zd});
        wait1();
        check("move dest", mem_at(da), ex);
        check("move writes", u_csmr_dmem_model.wr_cnt - w0, nw);
        check("move status", st, e_st);
        check("move pointer", fp, b);
        sync();
    endtask : t_mov
    task automatic give_verdict();
        $display("Comparisons %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : give_verdict
    // ----------------------------------------------------------------
    // Main sequence
    // ----------------------------------------------------------------
    initial begin
        {rst_n_in, valid_in, ext_in, fpld_in} = 4'h0;
        {instr_in, top_in, wsh_in, fsh_in, bsh_in, fpd_in} = '0;
        {e_w, e_st, e_bank} = '0;
        {fails, n_tests, cyc, takes, pops} = '0;
        repeat (3) @(posedge clk_in);
        rst_n_in <= 1'b1;
        wait1();
        check("reset pc", pc, 21'h000000);
        check("reset regs", {w, st, bank, fp}, 36'h000000000);
        sync();
        t_push();
        t_ret(1'b0);
        t_ret(1'b1);
        t_rot(1'b0, 1'b0, 1'b1, 8'h20, 8'he6, 12'h020);
        t_rot(1'b0, 1'b0, 1'b0, 8'ha0, 8'h80, 12'hfa0);
        t_rot(1'b0, 1'b1, 1'b1, 8'h40, 8'h01, 12'h340);
        load_fp(12'h200);
        t_rot(1'b1, 1'b0, 1'b1, 8'h10, 8'hff, 12'h210);
        t_rot(1'b1, 1'b0, 1'b0, 8'h60, 8'h7f, 12'hf60);
        t_mov(12'h080, 7'h05, 7'h06, 4'hf, 8'h33, 8'h33, 1);
        t_mov(12'h0f0, 7'h7f, 7'h00, 4'hf, 8'h9e, 8'h9e, 1);
        t_mov(12'hfd9, 7'h07, 7'h00, 4'hf, 8'h55, 8'h00, 1);
        t_mov(12'hf80, 7'h00, 7'h70, 4'hf, 8'h44, 8'hc3, 0);
        t_mov(12'h080, 7'h05, 7'h06, 4'he, 8'h33, 8'hc3, 0);
        give_verdict();
    end
endmodule : cpu_stack_move_rotate_ops_bench
